// ===== dv/clk_far_side.sv
`timescale 1ns/1ns
// Stands in for the board: strap resistor, crystal and PLL lock detector.
module clk_far_side (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic pllEnable,
	input wire logic strapLevel,
	input wire logic refOut,
	input wire logic refOe,
	output logic crystal,
	output logic locked,
	output logic pinLevel
);
	logic [4:0] lockCnt_r;
	logic [1:0] xtalCnt_r;
	// The strap resistor only sets the pin while the device leaves it undriven.
	assign pinLevel = refOe ? refOut : strapLevel;
	assign locked = (lockCnt_r == 5'h14);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			xtalCnt_r <= 2'h0;
			crystal <= 1'b0;
		end else if (xtalCnt_r == 2'h2) begin
			xtalCnt_r <= 2'h0;
			crystal <= ~crystal;
		end else begin
			xtalCnt_r <= xtalCnt_r + 2'h1;
		end
	end
	// Lock comes slowly so that blocked outputs can be seen first.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lockCnt_r <= 5'h00;
		end else if (pllEnable && !locked) begin
			lockCnt_r <= lockCnt_r + 5'h01;
		end
	end
endmodule

// ===== dv/clock_output_power_control_tb.sv
`timescale 1ns/1ns
module clock_output_power_control_tb
	import clk_ctrl_pkg::*;
;
	typedef struct packed {logic wr; logic [2:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	row_t rows [9] = '{'{1'b0, 3'h0, 8'h00, 8'h3F}, '{1'b0, 3'h1, 8'h00, 8'h3F},
		'{1'b0, 3'h2, 8'h00, 8'h08}, '{1'b0, 3'h3, 8'h00, 8'h5F},
		'{1'b0, 3'h5, 8'h00, 8'h00}, '{1'b1, 3'h2, 8'h05, 8'h00},
		'{1'b0, 3'h2, 8'h00, 8'h05}, '{1'b1, 3'h4, 8'hFF, 8'h00},
		'{1'b0, 3'h4, 8'h00, 8'h00}};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic power_good_down_n = 1'b0;
	logic [PAIR_COUNT-1:0] pair_enable_n = 6'h3E;
	logic spreadHi = 1'b0;
	logic spreadMid = 1'b1;
	logic strapLevel = 1'b1;
	logic [ADDR_W-1:0] regAddr = 3'h0;
	logic [DATA_W-1:0] regWriteData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [DATA_W-1:0] regReadData, rd;
	logic crystal, locked, pinLevel, refOut, refOe, pllEnable;
	logic [PAIR_COUNT-1:0] diffOut, diffComp;
	logic [6:0] busAddress;
	logic [1:0] spreadMode;
	logic [AMPL_W-1:0] amplitudeSelect;
	logic [PAIR_COUNT:0] slewSelect;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int dt, rt;
	always #2 sys_clk = ~sys_clk;
	clk_far_side far_u (.sys_clk(sys_clk), .resetn(resetn), .pllEnable(pllEnable),
		.strapLevel(strapLevel), .refOut(refOut), .refOe(refOe), .crystal(crystal),
		.locked(locked), .pinLevel(pinLevel));
	clock_output_power_control #(.LOCK_WAIT_CYCLES(50), .HALF_CYCLES(2)) dut_u (
		.sys_clk(sys_clk), .resetn(resetn), .power_good_down_n(power_good_down_n),
		.pair_enable_n(pair_enable_n), .spreadStrapHigh(spreadHi),
		.spreadStrapMid(spreadMid), .crystalClockIn(crystal), .pllLocked(locked),
		.bus_address_strap_in(pinLevel), .bus_address_strap_out(refOut),
		.bus_address_strap_oe(refOe), .diff_clock_out(diffOut),
		.diff_clock_comp_out(diffComp), .busAddress(busAddress), .spreadMode(spreadMode),
		.pllEnable(pllEnable), .slewSelect(slewSelect), .amplitudeSelect(amplitudeSelect),
		.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
		.regRead(regRead), .regReadData(regReadData));
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1;
		d = regReadData;
	endtask
	// Counts level changes of pair 0 and of the reference pin over n cycles.
	task automatic watch(input int n, output int dc, output int rc);
		logic d0, r0;
		dc = 0;
		rc = 0;
		for (int i = 0; i < n; i++) begin
			d0 = diffOut[0];
			r0 = refOut;
			wait_cyc(1);
			if (diffOut[0] !== d0) dc++;
			if (refOut !== r0) rc++;
		end
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		#1;
		chk({1'b0, busAddress}, {1'b0, BUS_ADDR_STRAP_LOW});
		chk({7'h00, refOe}, 8'h00);
		for (int i = 0; i < 9; i++) begin
			if (rows[i].wr) begin
				reg_wr(rows[i].a, rows[i].d);
			end else begin
				reg_rd(rows[i].a, rd);
				chk(rd, rows[i].e);
			end
		end
		chk({4'h0, amplitudeSelect}, 8'h05);
		chk({1'b0, slewSelect}, 8'h7F);
		@(posedge sys_clk);
		power_good_down_n <= 1'b1;
		wait_cyc(6);
		chk({1'b0, busAddress}, {1'b0, BUS_ADDR_STRAP_HIGH});
		chk({6'h00, spreadMode}, {6'h00, SPREAD_QUARTER});
		chk({7'h00, refOe}, 8'h01);
		chk({2'h0, diffOut | diffComp}, 8'h00);
		@(posedge sys_clk);
		strapLevel <= 1'b0;
		spreadHi <= 1'b1;
		wait_cyc(30);
		chk({1'b0, busAddress}, {1'b0, BUS_ADDR_STRAP_HIGH});
		chk({6'h00, spreadMode}, {6'h00, SPREAD_QUARTER});
		watch(16, dt, rt);
		chk({7'h00, dt > 3}, 8'h01);
		chk({7'h00, rt > 1}, 8'h01);
		chk({2'h0, diffOut[5:1], diffComp[0] ^ diffOut[0]}, 8'h01);
		reg_rd(OFS_STATUS, rd);
		chk(rd & 8'h07, 8'h02);
		reg_wr(OFS_PAIR_ENABLE, 8'h3E);
		wait_cyc(8);
		chk({2'h0, diffOut | diffComp}, 8'h00);
		reg_wr(OFS_PAIR_ENABLE, 8'h3F);
		pair_enable_n <= 6'h3F;
		wait_cyc(8);
		chk({2'h0, diffOut | diffComp}, 8'h00);
		@(posedge sys_clk);
		pair_enable_n <= 6'h3E;
		wait_cyc(8);
		watch(4, dt, rt);
		chk({7'h00, dt > 0}, 8'h01);
		@(posedge sys_clk);
		power_good_down_n <= 1'b0;
		wait_cyc(8);
		chk({2'h0, diffOut | diffComp}, 8'h00);
		chk({6'h00, refOe, refOut}, 8'h02);
		reg_rd(OFS_STATUS, rd);
		chk(rd & 8'h07, 8'h03);
		reg_wr(OFS_REF_CONFIG, 8'h7F);
		wait_cyc(4);
		watch(16, dt, rt);
		chk({7'h00, rt > 1}, 8'h01);
		chk({7'h00, dt == 0}, 8'h01);
		@(posedge sys_clk);
		power_good_down_n <= 1'b1;
		wait_cyc(12);
		watch(8, dt, rt);
		chk({7'h00, dt > 1}, 8'h01);
		finish_test();
	end
endmodule

// ===== hdl/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

	localparam int PAIR_COUNT = 6;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// Byte-wide configuration map, one byte per index.
	localparam logic [2:0] OFS_PAIR_ENABLE = 3'h0;
	localparam logic [2:0] OFS_PAIR_SLEW = 3'h1;
	localparam logic [2:0] OFS_AMPLITUDE = 3'h2;
	localparam logic [2:0] OFS_REF_CONFIG = 3'h3;
	localparam logic [2:0] OFS_STATUS = 3'h4;

	localparam int REF_WAKE_BIT = 5;
	localparam int REF_SLEW_LSB = 6;
	localparam int AMPL_W = 4;

	localparam logic [7:0] RST_PAIR_ENABLE = 8'h3F;
	localparam logic [7:0] RST_PAIR_SLEW = 8'h3F;
	localparam logic [7:0] RST_AMPLITUDE = 8'h08;
	localparam logic [7:0] RST_REF_CONFIG = 8'h5F;

	localparam logic [6:0] BUS_ADDR_STRAP_LOW = 7'h68;
	localparam logic [6:0] BUS_ADDR_STRAP_HIGH = 7'h6A;

	localparam logic [1:0] SPREAD_OFF = 2'h0;
	localparam logic [1:0] SPREAD_QUARTER = 2'h1;
	localparam logic [1:0] SPREAD_HALF = 2'h2;

	localparam int CLK_MHZ = 250;
	localparam int T_DRIVE_PD_US = 300;
	localparam int DRIVE_PD_CYCLES = T_DRIVE_PD_US * CLK_MHZ;
	localparam int HALF_PERIOD_CYCLES = 2;

	typedef enum logic [2:0] {
		WAIT_FIRST,
		START_LOCK,
		RUN,
		POWER_DOWN,
		WAKE_LOCK
	} pwr_state_t;

endpackage

// ===== hdl/clock_output_power_control.sv
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module clock_output_power_control
	import clk_ctrl_pkg::*;
#(
	parameter int LOCK_WAIT_CYCLES = DRIVE_PD_CYCLES,
	parameter int HALF_CYCLES = HALF_PERIOD_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic power_good_down_n,
	input wire logic [PAIR_COUNT-1:0] pair_enable_n,
	input wire logic spreadStrapHigh,
	input wire logic spreadStrapMid,
	input wire logic crystalClockIn,
	input wire logic pllLocked,
	input wire logic bus_address_strap_in,
	output logic bus_address_strap_out,
	output logic bus_address_strap_oe,
	output logic [PAIR_COUNT-1:0] diff_clock_out,
	output logic [PAIR_COUNT-1:0] diff_clock_comp_out,
	output logic [6:0] busAddress,
	output logic [1:0] spreadMode,
	output logic pllEnable,
	output logic [PAIR_COUNT:0] slewSelect,
	output logic [AMPL_W-1:0] amplitudeSelect,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regReadData
);

	localparam int LOCK_CNT_W = $clog2(LOCK_WAIT_CYCLES + 1);
	localparam int HALF_CNT_W = $clog2(HALF_CYCLES + 1);

	// Two-flop synchronisers for every pin except resetn and the register port, and the PLL lock flag.
	logic pgMeta_r, pgSync_r;
	logic [PAIR_COUNT-1:0] pinMeta_r, pinSync_r;
	logic spHiMeta_r, spHiSync_r, spMidMeta_r, spMidSync_r;
	logic xtalMeta_r, xtalSync_r;
	logic lockMeta_r, lockSync_r;
	logic addrMeta_r, addrSync_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pgMeta_r <= 1'b0;
			pgSync_r <= 1'b0;
			pinMeta_r <= '1;
			pinSync_r <= '1;
			spHiMeta_r <= 1'b0;
			spHiSync_r <= 1'b0;
			spMidMeta_r <= 1'b0;
			spMidSync_r <= 1'b0;
			xtalMeta_r <= 1'b0;
			xtalSync_r <= 1'b0;
			lockMeta_r <= 1'b0;
			lockSync_r <= 1'b0;
			addrMeta_r <= 1'b0;
			addrSync_r <= 1'b0;
		end else begin
			pgMeta_r <= power_good_down_n;
			pgSync_r <= pgMeta_r;
			pinMeta_r <= pair_enable_n;
			pinSync_r <= pinMeta_r;
			spHiMeta_r <= spreadStrapHigh;
			spHiSync_r <= spHiMeta_r;
			spMidMeta_r <= spreadStrapMid;
			spMidSync_r <= spMidMeta_r;
			xtalMeta_r <= crystalClockIn;
			xtalSync_r <= xtalMeta_r;
			lockMeta_r <= pllLocked;
			lockSync_r <= lockMeta_r;
			addrMeta_r <= bus_address_strap_in;
			addrSync_r <= addrMeta_r;
		end
	end

	// Power sequencing.
	pwr_state_t state_r, stateNxt;
	logic [LOCK_CNT_W-1:0] lockWait_r;
	logic lockLate_r;
	logic strapsLatched_r;

	always_comb begin
		stateNxt = state_r;
		unique case (state_r)
			WAIT_FIRST: if (pgSync_r) stateNxt = START_LOCK;
			START_LOCK: if (!pgSync_r) stateNxt = POWER_DOWN;
				else if (lockSync_r) stateNxt = RUN;
			RUN: if (!pgSync_r) stateNxt = POWER_DOWN;
			POWER_DOWN: if (pgSync_r) stateNxt = WAKE_LOCK;
			WAKE_LOCK: if (!pgSync_r) stateNxt = POWER_DOWN;
				else if (lockSync_r) stateNxt = RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= WAIT_FIRST;
		end else begin
			state_r <= stateNxt;
		end
	end

	// The pairs stay blocked until lock even past the wake budget; the budget only
	// flags a late lock so software can see the PLL broke its start-up window.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lockWait_r <= '0;
			lockLate_r <= 1'b0;
		end else if (state_r == WAKE_LOCK || state_r == START_LOCK) begin
			if (lockWait_r == LOCK_CNT_W'(LOCK_WAIT_CYCLES)) begin
				lockLate_r <= 1'b1;
			end else begin
				lockWait_r <= lockWait_r + 1'b1;
			end
		end else begin
			lockWait_r <= '0;
		end
	end

	// Straps are captured once; later changes on the pins are ignored.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strapsLatched_r <= 1'b0;
			busAddress <= BUS_ADDR_STRAP_LOW;
			spreadMode <= SPREAD_OFF;
		end else if (state_r == WAIT_FIRST && pgSync_r) begin
			strapsLatched_r <= 1'b1;
			busAddress <= addrSync_r ? BUS_ADDR_STRAP_HIGH : BUS_ADDR_STRAP_LOW;
			spreadMode <= spHiSync_r ? SPREAD_HALF :
				(spMidSync_r ? SPREAD_QUARTER : SPREAD_OFF);
		end
	end

	// Configuration bytes; reset values run every output with no bus access.
	logic [DATA_W-1:0] pairEnable_r, pairSlew_r, amplitude_r, refConfig_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pairEnable_r <= RST_PAIR_ENABLE;
			pairSlew_r <= RST_PAIR_SLEW;
			amplitude_r <= RST_AMPLITUDE;
			refConfig_r <= RST_REF_CONFIG;
		end else if (regWrite) begin
			unique case (regAddr)
				OFS_PAIR_ENABLE: pairEnable_r <= regWriteData;
				OFS_PAIR_SLEW: pairSlew_r <= regWriteData;
				OFS_AMPLITUDE: amplitude_r <= regWriteData;
				OFS_REF_CONFIG: refConfig_r <= regWriteData;
				default: ;
			endcase
		end
	end

	logic wakeKeepReference;
	logic [DATA_W-1:0] statusByte;
	assign wakeKeepReference = refConfig_r[REF_WAKE_BIT];
	assign statusByte = {lockLate_r, lockSync_r, strapsLatched_r, spreadMode, state_r};

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			regReadData <= '0;
		end else if (regRead) begin
			unique case (regAddr)
				OFS_PAIR_ENABLE: regReadData <= {2'h0, pairEnable_r[PAIR_COUNT-1:0]};
				OFS_PAIR_SLEW: regReadData <= {2'h0, pairSlew_r[PAIR_COUNT-1:0]};
				OFS_AMPLITUDE: regReadData <= {4'h0, amplitude_r[AMPL_W-1:0]};
				OFS_REF_CONFIG: regReadData <= refConfig_r;
				OFS_STATUS: regReadData <= statusByte;
				default: regReadData <= '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			slewSelect <= '0;
			amplitudeSelect <= '0;
			pllEnable <= 1'b0;
		end else begin
			slewSelect <= {refConfig_r[REF_SLEW_LSB], pairSlew_r[PAIR_COUNT-1:0]};
			amplitudeSelect <= amplitude_r[AMPL_W-1:0];
			// The PLL is kept alive in power-down; it is the pairs that are cut.
			pllEnable <= (state_r != WAIT_FIRST);
		end
	end

	// Reference output shares the address strap pin once the strap is latched.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus_address_strap_oe <= 1'b0;
			bus_address_strap_out <= 1'b0;
		end else begin
			bus_address_strap_oe <= strapsLatched_r;
			if (state_r == POWER_DOWN && !wakeKeepReference) begin
				bus_address_strap_out <= 1'b0;
			end else begin
				bus_address_strap_out <= strapsLatched_r & xtalSync_r;
			end
		end
	end

	// Output clock phase, one toggle every HALF_CYCLES system clocks.
	logic [HALF_CNT_W-1:0] halfCount_r;
	logic phase_r;
	logic tick;
	assign tick = (halfCount_r == HALF_CNT_W'(HALF_CYCLES - 1));

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			halfCount_r <= '0;
			phase_r <= 1'b0;
		end else if (tick) begin
			halfCount_r <= '0;
			phase_r <= ~phase_r;
		end else begin
			halfCount_r <= halfCount_r + 1'b1;
		end
	end

	logic pairsOpen;
	assign pairsOpen = (state_r == RUN) && pgSync_r && lockSync_r;

	genvar gi;
	generate
		for (gi = 0; gi < PAIR_COUNT; gi++) begin : g_pair
			pair_gate u_gate (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.tick(tick),
				.phase(phase_r),
				.allow(pairsOpen && pairEnable_r[gi] && !pinSync_r[gi]),
				.diffTrue(diff_clock_out[gi]),
				.diffComp(diff_clock_comp_out[gi])
			);
		end
	endgenerate

	a_ref_hiz_first: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_r == WAIT_FIRST) |=> !bus_address_strap_oe)
		else $error("Reference pin driven before first power-good.");
	a_addr_from_strap: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(strapsLatched_r) |-> busAddress ==
			($past(addrSync_r) ? BUS_ADDR_STRAP_HIGH : BUS_ADDR_STRAP_LOW))
		else $error("Bus address does not match the sampled strap.");
	a_straps_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
		(strapsLatched_r && $past(strapsLatched_r)) |-> ($stable(spreadMode) && $stable(busAddress)))
		else $error("Latched strap value changed after capture.");
	a_pd_ref_low: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_r == POWER_DOWN && !wakeKeepReference) |=> !bus_address_strap_out)
		else $error("Reference runs in power-down without wake option.");
	a_pd_pairs_low: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!pgSync_r) [*8] |-> (diff_clock_out == '0 && diff_clock_comp_out == '0))
		else $error("Pairs still active with power-good low.");
	a_unlocked_blocked: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!lockSync_r) [*8] |-> (diff_clock_out == '0 && diff_clock_comp_out == '0))
		else $error("Pairs active without PLL lock.");
	a_wake_resume: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_r == POWER_DOWN && pgSync_r) |=> (state_r == WAKE_LOCK) ##1 (lockSync_r [*1]) |=>
		(state_r == RUN || !pgSync_r))
		else $error("Power-good high did not leave power-down.");
	a_status_read: assert property (@(posedge sys_clk) disable iff (!resetn)
		(regRead && regAddr == OFS_STATUS) |=> regReadData == $past(statusByte))
		else $error("Status read returned wrong data.");

	c_first_startup: cover property (@(posedge sys_clk) disable iff (!resetn)
		state_r == START_LOCK ##[1:100] state_r == RUN);
	c_wake_ref: cover property (@(posedge sys_clk) disable iff (!resetn)
		state_r == POWER_DOWN && wakeKeepReference && bus_address_strap_out);
	c_pair_running: cover property (@(posedge sys_clk) disable iff (!resetn)
		$rose(diff_clock_out[0]));

endmodule

// ===== hdl/pair_gate.sv
`timescale 1ns/1ns
module pair_gate
	import clk_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic phase,
	input wire logic allow,
	output logic diffTrue,
	output logic diffComp
);

	logic gate_r;
	logic gateNxt;
	logic phaseNxt;

	assign phaseNxt = tick ? ~phase : phase;
	// The gate only moves on the boundary where the true leg is about to rise.
	assign gateNxt = (tick && !phase) ? allow : gate_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			gate_r <= 1'b0;
		end else begin
			gate_r <= gateNxt;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			diffTrue <= 1'b0;
			diffComp <= 1'b0;
		end else begin
			diffTrue <= gateNxt & phaseNxt;
			diffComp <= gateNxt & ~phaseNxt;
		end
	end

	a_gate_closed_low: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!allow) [*8] |-> (!diffTrue && !diffComp))
		else $error("Pair still toggles after its enable was removed.");
	a_gate_boundary_only: assert property (@(posedge sys_clk) disable iff (!resetn)
		$changed(gate_r) |-> ($past(tick) && !$past(phase)))
		else $error("Pair gate changed away from a rising boundary.");
	a_legs_never_both: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(diffTrue && diffComp))
		else $error("Both legs of a pair are high.");

endmodule
